// [pmtr_pkg.sv]
// package: constants and types for the program memory table read block
package pmtr_pkg;
  localparam int          PMTR_ADDR_W     = 11;
  localparam int          PMTR_WORD_W     = 15;
  localparam int          PMTR_PAGE_W     = 8;
  localparam int          PMTR_PAGE_SEL_W = PMTR_ADDR_W - PMTR_PAGE_W;
  localparam int          PMTR_DEPTH      = 2048;
  localparam int          PMTR_RAM_AW     = 8;
  localparam int          PMTR_HI_W       = 7;
  localparam logic [10:0] PMTR_RESET_VEC  = 11'h000;
  localparam logic [7:0]  PMTR_PTR_RST    = 8'h00;
  localparam logic [6:0]  PMTR_HI_RST     = 7'h00;
  localparam logic [1:0]  PMTR_VAR_1K14   = 2'h0;
  localparam logic [1:0]  PMTR_VAR_2K14   = 2'h1;
  localparam logic [1:0]  PMTR_VAR_2K15   = 2'h2;
  localparam logic [2:0]  PMTR_LAST_1K    = 3'h3;
  localparam logic [2:0]  PMTR_LAST_2K    = 3'h7;
  localparam logic [1:0]  PMTR_TAB_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    PMTR_IDLE  = 2'b00,
    PMTR_READ  = 2'b01,
    PMTR_WRITE = 2'b11
  } pmtr_state_t;
endpackage

// [pmtr_flash_array.sv]
// module: program flash word array with synchronous read and serial-load write port
`timescale 1ns/1ps
module pmtr_flash_array
  import pmtr_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic [PMTR_ADDR_W-1:0] rd_addr_i,
  output logic      [PMTR_WORD_W-1:0] rd_data_o,
  input  wire logic                   wr_en_i,
  input  wire logic [PMTR_ADDR_W-1:0] wr_addr_i,
  input  wire logic [PMTR_WORD_W-1:0] wr_data_i
);
  logic [PMTR_WORD_W-1:0] mem [PMTR_DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // pmtr_flash_array

// [pmtr_table_read.sv]
// module: program memory fetch and table read unit
`timescale 1ns/1ps
module pmtr_table_read
  import pmtr_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire logic [1:0]             variant_i,
  input  wire logic                   fetch_i,
  input  wire logic                   jump_i,
  input  wire logic [PMTR_ADDR_W-1:0] jump_addr_i,
  output logic      [PMTR_ADDR_W-1:0] pc_o,
  output logic      [PMTR_WORD_W-1:0] instr_o,
  output logic                        instr_valid_o,
  input  wire logic                   ptr_wr_i,
  input  wire logic [7:0]             ptr_wdata_i,
  input  wire logic                   tab_rd_i,
  input  wire logic                   tab_last_i,
  input  wire logic [PMTR_RAM_AW-1:0] tab_dest_i,
  output logic                        busy_o,
  output logic                        ram_we_o,
  output logic      [PMTR_RAM_AW-1:0] ram_addr_o,
  output logic      [7:0]             ram_wdata_o,
  output logic      [7:0]             table_high_byte_reg_o,
  output logic      [7:0]             table_ptr_o,
  input  wire logic                   prog_mode_i,
  input  wire logic                   prog_serial_clock_i,
  input  wire logic                   prog_serial_data_i,
  output logic                        prog_serial_data_o,
  output logic                        prog_serial_data_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [PMTR_ADDR_W-1:0] pmtr_mask(
    input logic [PMTR_ADDR_W-1:0] a, input logic [1:0] v);
    pmtr_mask = (v == PMTR_VAR_1K14) ? {1'b0, a[PMTR_ADDR_W-2:0]} : a;
  endfunction

  function automatic logic [PMTR_WORD_W-1:0] pmtr_wmask(
    input logic [PMTR_WORD_W-1:0] w, input logic [1:0] v);
    pmtr_wmask = (v == PMTR_VAR_2K15) ? w : {1'b0, w[PMTR_WORD_W-2:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  pmtr_state_t            state_r, state_nxt;
  logic [PMTR_ADDR_W-1:0] pc_r, pc_nxt;
  logic [7:0]             ptr_r, ptr_nxt;
  logic [PMTR_HI_W-1:0]   hi_r, hi_nxt;
  logic [PMTR_RAM_AW-1:0] dest_r, dest_nxt;
  logic                   we_r, we_nxt;
  logic [7:0]             wdata_r, wdata_nxt;
  logic                   ivalid_r, ivalid_nxt;
  logic                   busy_r, busy_nxt;
  logic [PMTR_WORD_W-1:0] instr_r, instr_nxt;
  logic [PMTR_ADDR_W-1:0] rd_addr;
  logic [PMTR_WORD_W-1:0] rd_data;
  logic [PMTR_WORD_W-1:0] word;
  logic [PMTR_ADDR_W-1:0] tab_addr;
  logic [PMTR_PAGE_SEL_W-1:0] page_base;

  // serial programming state
  logic                   sck_d_r, sck_d_nxt;
  logic [4:0]             sbit_r, sbit_nxt;
  logic [PMTR_WORD_W-1:0] sshift_r, sshift_nxt;
  logic [PMTR_ADDR_W-1:0] saddr_r, saddr_nxt;
  logic                   swe_r, swe_nxt;
  logic                   sdo_r, sdo_nxt;
  logic                   soe_n_r, soe_n_nxt;

  ////////////////////////////////////////////////////////////////////////
  // page base from current or last page
  always_comb begin
    if (tab_last_i) begin
      page_base = (variant_i == PMTR_VAR_1K14) ? PMTR_LAST_1K : PMTR_LAST_2K;
    end else begin
      page_base = pc_r[PMTR_ADDR_W-1:PMTR_PAGE_W];
    end
    tab_addr = pmtr_mask({page_base, ptr_r}, variant_i);
  end

  always_comb begin
    rd_addr = prog_mode_i ? saddr_r : pc_r;
    if (state_r == PMTR_IDLE && tab_rd_i && !prog_mode_i) begin
      rd_addr = tab_addr;
    end
  end

  pmtr_flash_array u_flash (
    .ref_clk_i (ref_clk_i),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data),
    .wr_en_i   (swe_r),
    .wr_addr_i (saddr_r),
    .wr_data_i (sshift_r)
  );

  assign word = pmtr_wmask(rd_data, variant_i);

  ////////////////////////////////////////////////////////////////////////
  // fetch and table read sequencing
  always_comb begin
    state_nxt  = state_r;
    pc_nxt     = pc_r;
    ptr_nxt    = ptr_r;
    hi_nxt     = hi_r;
    dest_nxt   = dest_r;
    we_nxt     = 1'b0;
    wdata_nxt  = wdata_r;
    ivalid_nxt = 1'b0;
    instr_nxt  = instr_r;
    if (ptr_wr_i) begin
      ptr_nxt = ptr_wdata_i;
    end
    unique case (state_r)
      PMTR_IDLE: begin
        if (prog_mode_i) begin
          state_nxt = PMTR_IDLE;
        end else if (tab_rd_i) begin
          dest_nxt  = tab_dest_i;
          state_nxt = PMTR_READ;
        end else if (jump_i) begin
          pc_nxt = pmtr_mask(jump_addr_i, variant_i);
        end else if (fetch_i) begin
          ivalid_nxt = 1'b1;
          instr_nxt  = word;
          pc_nxt     = pmtr_mask(pc_r + 11'h001, variant_i);
        end
      end
      PMTR_READ: begin
        we_nxt    = 1'b1;
        wdata_nxt = word[7:0];
        hi_nxt    = word[PMTR_WORD_W-1:8];
        state_nxt = PMTR_WRITE;
      end
      PMTR_WRITE: begin
        state_nxt = PMTR_IDLE;
      end
      default: state_nxt = PMTR_IDLE;
    endcase
    busy_nxt = (state_nxt != PMTR_IDLE);
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r  <= PMTR_IDLE;
      pc_r     <= PMTR_RESET_VEC;
      ptr_r    <= PMTR_PTR_RST;
      hi_r     <= PMTR_HI_RST;
      dest_r   <= '0;
      we_r     <= 1'b0;
      wdata_r  <= 8'h00;
      ivalid_r <= 1'b0;
      instr_r  <= '0;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      pc_r     <= pc_nxt;
      ptr_r    <= ptr_nxt;
      hi_r     <= hi_nxt;
      dest_r   <= dest_nxt;
      we_r     <= we_nxt;
      wdata_r  <= wdata_nxt;
      ivalid_r <= ivalid_nxt;
      instr_r  <= instr_nxt;
      busy_r   <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial programming port; shared with debug pins on the emulation part
  always_comb begin
    sck_d_nxt  = prog_serial_clock_i;
    sbit_nxt   = sbit_r;
    sshift_nxt = sshift_r;
    saddr_nxt  = saddr_r;
    swe_nxt    = 1'b0;
    sdo_nxt    = sdo_r;
    soe_n_nxt  = 1'b1;
    if (!prog_mode_i) begin
      sbit_nxt = 5'h00;
    end else begin
      soe_n_nxt = ~saddr_r[0] ? 1'b1 : 1'b0;
      if (prog_serial_clock_i && !sck_d_r) begin
        sshift_nxt = {sshift_r[PMTR_WORD_W-2:0], prog_serial_data_i};
        sdo_nxt    = word[PMTR_WORD_W-1];
        if (sbit_r == 5'(PMTR_WORD_W - 1)) begin
          sbit_nxt = 5'h00;
          swe_nxt  = ~saddr_r[0];
          // read-out words write nothing, so step the address here
          if (saddr_r[0]) begin
            saddr_nxt = pmtr_mask(saddr_r + 11'h001, variant_i);
          end
        end else begin
          sbit_nxt = sbit_r + 5'h01;
        end
      end
      if (swe_r) begin
        saddr_nxt = pmtr_mask(saddr_r + 11'h001, variant_i);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_d_r  <= 1'b0;
      sbit_r   <= 5'h00;
      sshift_r <= '0;
      saddr_r  <= PMTR_RESET_VEC;
      swe_r    <= 1'b0;
      sdo_r    <= 1'b0;
      soe_n_r  <= 1'b1;
    end else begin
      sck_d_r  <= sck_d_nxt;
      sbit_r   <= sbit_nxt;
      sshift_r <= sshift_nxt;
      saddr_r  <= saddr_nxt;
      swe_r    <= swe_nxt;
      sdo_r    <= sdo_nxt;
      soe_n_r  <= soe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign pc_o                    = pc_r;
  assign instr_o                 = instr_r;
  assign instr_valid_o           = ivalid_r;
  assign busy_o                  = busy_r;
  assign ram_we_o                = we_r;
  assign ram_addr_o              = dest_r;
  assign ram_wdata_o             = wdata_r;
  assign table_high_byte_reg_o   = {1'b0, hi_r};
  assign table_ptr_o             = ptr_r;
  assign prog_serial_data_o      = sdo_r;
  assign prog_serial_data_oe_n_o = soe_n_r;

endmodule // pmtr_table_read

// [pmtr_chk_sva.sv]
// checker: table read timing, high byte and pointer behaviour
`timescale 1ns/1ps
module pmtr_chk
  import pmtr_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [1:0]  variant_i,
  input wire logic        tab_rd_i,
  input wire logic [7:0]  tab_dest_i,
  input wire logic        busy_o,
  input wire logic        ram_we_o,
  input wire logic [7:0]  ram_addr_o,
  input wire logic [7:0]  table_high_byte_reg_o,
  input wire logic        ptr_wr_i,
  input wire logic [7:0]  ptr_wdata_i,
  input wire logic [7:0]  table_ptr_o,
  input wire logic        prog_mode_i,
  input wire logic        prog_serial_data_oe_n_o,
  input wire logic [10:0] pc_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic take;
  assign take = tab_rd_i & ~busy_o & ~prog_mode_i;
  chk_two_cycle: assert property (take |=> busy_o ##1 (busy_o && ram_we_o) ##1 !busy_o)
    else $error("table read timing wrong");
  chk_we_cause: assert property (ram_we_o |-> $past(take, 2))
    else $error("write pulse without a taken read");
  chk_dest_addr: assert property (ram_we_o |-> ram_addr_o == $past(tab_dest_i, 2))
    else $error("destination address wrong");
  chk_hi_top: assert property (table_high_byte_reg_o[7] == 1'b0)
    else $error("high byte top bit set");
  chk_hi_narrow: assert property (ram_we_o && variant_i != PMTR_VAR_2K15 |->
    !table_high_byte_reg_o[6]) else $error("narrow word high bit set");
  chk_hi_hold: assert property (!ram_we_o |-> $stable(table_high_byte_reg_o))
    else $error("high byte changed without a read");
  chk_ptr_load: assert property (ptr_wr_i && !prog_mode_i |=> table_ptr_o == $past(ptr_wdata_i))
    else $error("table pointer not loaded");
  chk_pc_vector: assert property ($fell(reset_i) |-> pc_o == PMTR_RESET_VEC)
    else $error("fetch does not start at zero");
  chk_oe_idle: assert property (!prog_mode_i && !$past(prog_mode_i) |-> prog_serial_data_oe_n_o)
    else $error("serial data driven outside programming");
endmodule // pmtr_chk
bind pmtr_table_read pmtr_chk u_chk (.ref_clk_i, .reset_i, .variant_i, .tab_rd_i, .tab_dest_i,
  .busy_o, .ram_we_o, .ram_addr_o, .table_high_byte_reg_o, .ptr_wr_i, .ptr_wdata_i,
  .table_ptr_o, .prog_mode_i, .prog_serial_data_oe_n_o, .pc_o);

// [pmtr_core_model.sv]
// core model: issues pointer writes and table reads
`timescale 1ns/1ps
module pmtr_core_model (
  input  wire logic ref_clk_i,
  output logic      ptr_wr_o,
  output logic [7:0] ptr_wdata_o,
  output logic      tab_rd_o,
  output logic      tab_last_o,
  output logic [7:0] tab_dest_o
);
  initial begin
    ptr_wr_o = 1'b0;
    ptr_wdata_o = 8'h00;
    tab_rd_o = 1'b0;
    tab_last_o = 1'b0;
    tab_dest_o = 8'h00;
  end
  task automatic ptr(input logic [7:0] v);
    @(negedge ref_clk_i);
    ptr_wr_o = 1'b1;
    ptr_wdata_o = v;
    @(negedge ref_clk_i);
    ptr_wr_o = 1'b0;
    ptr_wdata_o = ~v;
  endtask
  // held n cycles; a hold of up to two cycles past the take is ignored by the block
  task automatic rd(input logic last, input logic [7:0] d, input int n);
    @(negedge ref_clk_i);
    tab_rd_o = 1'b1;
    tab_last_o = last;
    tab_dest_o = d;
    repeat (n) @(negedge ref_clk_i);
    tab_rd_o = 1'b0;
    tab_dest_o = ~d;
  endtask
endmodule // pmtr_core_model

// [pmtr_table_read_bench.sv]
// bench: programs flash serially, then checks fetch and table reads
`timescale 1ns/1ps
module pmtr_table_read_bench;
  import pmtr_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, fetch_i = 0, jump_i = 0, prog_mode_i = 0;
  logic prog_serial_clock_i = 0, sdat = 0, instr_valid_o, busy_o, ram_we_o;
  logic prog_serial_data_o, prog_serial_data_oe_n_o, ptr_wr_i, tab_rd_i, tab_last_i;
  logic [1:0] variant_i = PMTR_VAR_1K14;
  logic [10:0] jump_addr_i = 11'h000, pc_o;
  logic [14:0] instr_o, m [0:1023];
  logic [7:0] ptr_wdata_i, tab_dest_i, ram_addr_o, ram_wdata_o, table_high_byte_reg_o, table_ptr_o;
  logic [31:0] rnd = 32'hEAEA;
  int err_total = 0, checked = 0, cyc = 0, nwe = 0, nexp = 0;
  wire prog_serial_data_i = prog_serial_data_oe_n_o ? sdat : prog_serial_data_o;
  pmtr_table_read DUT (.ref_clk_i, .reset_i, .variant_i, .fetch_i, .jump_i, .jump_addr_i, .pc_o,
    .instr_o, .instr_valid_o, .ptr_wr_i, .ptr_wdata_i, .tab_rd_i, .tab_last_i, .tab_dest_i,
    .busy_o, .ram_we_o, .ram_addr_o, .ram_wdata_o, .table_high_byte_reg_o, .table_ptr_o,
    .prog_mode_i, .prog_serial_clock_i, .prog_serial_data_i, .prog_serial_data_o,
    .prog_serial_data_oe_n_o);
  pmtr_core_model CORE (.ref_clk_i, .ptr_wr_o(ptr_wr_i), .ptr_wdata_o(ptr_wdata_i),
    .tab_rd_o(tab_rd_i), .tab_last_o(tab_last_i), .tab_dest_o(tab_dest_i));
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (ram_we_o === 1'b1) nwe <= nwe + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sbit(input logic b);
    @(negedge ref_clk_i);
    sdat = b;
    @(negedge ref_clk_i);
    prog_serial_clock_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    prog_serial_clock_i = 1'b0;
  endtask
  task automatic end_sim;
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [10:0] a;
    logic [7:0] p;
    logic [1:0] pg;
    logic lst;
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    prog_mode_i = 1'b1;
    for (int i = 0; i < 11'h310; i++) begin
      rnd = xs(rnd);
      if (!i[0]) m[i] = rnd[14:0] & 15'h3FFF;
      for (int b = 14; b >= 0; b--) sbit(rnd[b]);
    end
    @(negedge ref_clk_i);
    prog_mode_i = 1'b0;
    reset_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    fetch_i = 1'b1;
    for (int k = 0; k < 8 && instr_valid_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk(instr_o, m[0]);
    fetch_i = 1'b0;
    for (int t = 0; t < 16; t++) begin
      rnd = xs(rnd);
      lst = t[0];
      pg = rnd[17:16] % 3;
      p = lst ? {4'h0, rnd[3:1], 1'b0} : {rnd[7:1], 1'b0};
      a = lst ? {3'h3, p} : {1'b0, pg, p};
      jump_addr_i = {1'b0, pg, rnd[15:8]};
      jump_i = 1'b1;
      @(negedge ref_clk_i);
      jump_i = 1'b0;
      CORE.ptr(p);
      CORE.rd(lst, rnd[31:24], t == 3 ? 2 : 1);
      nexp++;
      for (int k = 0; k < 8 && ram_we_o !== 1'b1; k++) @(negedge ref_clk_i);
      chk(ram_wdata_o, m[a][7:0]);
      chk(ram_addr_o, rnd[31:24]);
      chk(table_high_byte_reg_o, {1'b0, m[a][14:8]});
      chk(table_ptr_o, p);
      for (int k = 0; k < 8 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
    end
    prog_mode_i = 1'b1;
    CORE.rd(1'b0, 8'h11, 1);
    repeat (4) @(negedge ref_clk_i);
    prog_mode_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(nwe[15:0], nexp[15:0]);
    end_sim();
  end
endmodule // pmtr_table_read_bench
